// File: hw/fce_seq.sv
// Host-side chip-erase sequencer: pre-programs the array to zero, then runs
// erase pulses with per-byte erase-verify until the whole array reads erased or MAX_PULSES pulses have run.
// Assumes the flash pins are wired straight to the ports and VPP is already high.
// Summary of operation
// - Pre-program every byte to zero first.
// - Reset verify address and pulse count.
// - Erase pulse starts with two 20h writes.
// - Stay idle for the whole erase pulse.
// - Erase pulse idle lasts at least 9.5 ms.
// - Erase-verify write A0h ends the pulse.
// - Read addressed byte after recovery wait.
// - Recovery before read at least 6 us.
// - Compare with FFh, count every pulse.
// - Verify from zero upward until failure.
// - Resume verify at last verified address.
// - Write 00h to return to read mode.
// - Erase-verify only after a chip erase.
// - Chip select from decoder, output enable shared; here the bus engine of fce_seq drives FL_CE_N and FL_OE_N itself.
`timescale 1ns/100ps
`default_nettype none
module fce_seq #(
	parameter int ERASE_CYC  = fce_pkg::ERASE_PULSE_CYC,
	parameter int RECOV_CYC  = fce_pkg::RECOVERY_CYC,
	parameter int PROG_CYC   = fce_pkg::PROG_PULSE_CYC,
	parameter int LAST_ADDR  = (1 << fce_pkg::ADDR_W) - 1,
	parameter int MAX_PULSES = fce_pkg::MAX_ERASE_PULSES
) (
	input  wire logic                        CLK,
	input  wire logic                        RESET_N,
	input  wire logic                        START,
	output var  logic                        BUSY,
	output var  logic                        DONE,
	output var  logic                        FAIL,
	output var  logic [15:0]                 PULSE_COUNT,
	output var  logic [fce_pkg::ADDR_W-1:0]  FL_ADDR,
	output var  logic [fce_pkg::DATA_W-1:0]  FL_DQ_O,
	output var  logic                        FL_DQ_OE,
	input  wire logic [fce_pkg::DATA_W-1:0]  FL_DQ_I,
	output var  logic                        FL_CE_N,
	output var  logic                        FL_OE_N,
	output var  logic                        FL_WE_N
);
	typedef enum {
		S_IDLE, S_PP_SETUP, S_PP_DATA, S_PP_WAIT, S_PP_VERIFY, S_PP_READ,
		S_ER_SETUP, S_ER_EXEC, S_ER_WAIT, S_EV_CMD, S_EV_READ, S_READ_CMD
	} fce_state_e;

	typedef enum {B_IDLE, B_SETUP, B_STROBE, B_HOLD} fce_bus_e;

	localparam int AW = fce_pkg::ADDR_W;
	localparam int DW = fce_pkg::DATA_W;
	localparam logic [AW-1:0] LAST_A = AW'(LAST_ADDR);

	fce_state_e state_q;
	fce_bus_e   bus_q;
	logic [fce_pkg::TIMER_W-1:0] timer_q;
	logic [fce_pkg::TIMER_W-1:0] bus_cnt_q;
	logic [AW-1:0]  addr_q;
	logic [4:0]     prog_tries_q;
	logic [15:0]    pulses_q;
	logic           req_q;
	logic           req_rd_q;
	logic [DW-1:0]  req_data_q;
	logic           bus_done_q;
	logic [DW-1:0]  rd_data_q;
	logic           start_s1_q;
	logic           start_s2_q;
	logic [DW-1:0]  dq_s1_q;
	logic [DW-1:0]  dq_s2_q;
	logic           final_q;

	// True while the pulse budget has been spent.
	function automatic logic limit_hit(input logic [15:0] n);
		limit_hit = (32'(n) >= 32'(MAX_PULSES));
	endfunction : limit_hit

	// Start and read data come from outside, so both pass two flops first.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			start_s1_q <= 1'b0;
			start_s2_q <= 1'b0;
			dq_s1_q    <= '0;
			dq_s2_q    <= '0;
		end else begin
			start_s1_q <= START;
			start_s2_q <= start_s1_q;
			dq_s1_q    <= FL_DQ_I;
			dq_s2_q    <= dq_s1_q;
		end
	end

	// Bus cycle engine: one write or read cycle per request, data and chip
	// select set a cycle ahead of the strobe, so the device accepts the write.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			bus_q      <= B_IDLE;
			bus_cnt_q  <= '0;
			bus_done_q <= 1'b0;
			FL_CE_N    <= 1'b1;
			FL_OE_N    <= 1'b1;
			FL_WE_N    <= 1'b1;
			FL_DQ_O    <= '0;
			FL_DQ_OE   <= 1'b0;
			rd_data_q  <= '0;
		end else begin
			bus_done_q <= 1'b0;
			case (bus_q)
				B_IDLE: begin
					if (req_q && !bus_done_q) begin
						bus_q     <= B_SETUP;
						FL_CE_N   <= 1'b0;
						FL_DQ_O   <= req_data_q;
						FL_DQ_OE  <= !req_rd_q;
						bus_cnt_q <= '0;
					end
				end
				B_SETUP: begin
					// Chip select set-up ahead of the strobe.
					bus_q     <= B_STROBE;
					FL_WE_N   <= req_rd_q;
					FL_OE_N   <= !req_rd_q;
					bus_cnt_q <= '0;
				end
				B_STROBE: begin
					bus_cnt_q <= bus_cnt_q + 1'b1;
					if (32'(bus_cnt_q) >= (req_rd_q ? fce_pkg::ACCESS_CYC
					                                 : fce_pkg::STROBE_CYC) - 1) begin
						bus_q     <= B_HOLD;
						FL_WE_N   <= 1'b1;
						FL_OE_N   <= 1'b1;
						rd_data_q <= dq_s2_q;
						bus_cnt_q <= '0;
					end
				end
				B_HOLD: begin
					// Data hold after the strobe rises, then release the bus.
					bus_cnt_q <= bus_cnt_q + 1'b1;
					if (32'(bus_cnt_q) >= fce_pkg::GAP_CYC - 1) begin
						bus_q      <= B_IDLE;
						FL_CE_N    <= 1'b1;
						FL_DQ_OE   <= 1'b0;
						bus_done_q <= 1'b1;
					end
				end
				default: bus_q <= B_IDLE;
			endcase
		end
	end

	// Issue one bus cycle from the sequencer; held until the engine finishes.
	task automatic issue(input logic rd, input logic [DW-1:0] d);
		req_q      <= 1'b1;
		req_rd_q   <= rd;
		req_data_q <= d;
	endtask : issue

	// Main erase algorithm. Waits between commands are counted in timer_q,
	// which starts once the previous write cycle has ended, after its data hold.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_q      <= S_IDLE;
			timer_q      <= '0;
			addr_q       <= '0;
			prog_tries_q <= '0;
			pulses_q     <= '0;
			req_q        <= 1'b0;
			req_rd_q     <= 1'b0;
			req_data_q   <= '0;
			final_q      <= 1'b0;
			FL_ADDR      <= '0;
			PULSE_COUNT  <= '0;
			BUSY         <= 1'b0;
			DONE         <= 1'b0;
			FAIL         <= 1'b0;
		end else begin
			if (timer_q != '0) begin
				timer_q <= timer_q - 1'b1;
			end
			if (bus_done_q) begin
				req_q <= 1'b0;
			end
			PULSE_COUNT <= pulses_q;
			case (state_q)
				S_IDLE: begin
					if (start_s2_q) begin
						BUSY         <= 1'b1;
						DONE         <= 1'b0;
						FAIL         <= 1'b0;
						addr_q       <= '0;
						FL_ADDR      <= '0;
						prog_tries_q <= '0;
						pulses_q     <= '0;
						state_q      <= S_PP_SETUP;
						issue(1'b0, fce_pkg::CMD_PROG_SETUP);
					end
				end
				S_PP_SETUP: begin
					if (bus_done_q) begin
						state_q <= S_PP_DATA;
						issue(1'b0, fce_pkg::PROG_VALUE);
					end
				end
				S_PP_DATA: begin
					if (bus_done_q) begin
						state_q <= S_PP_WAIT;
						timer_q <= fce_pkg::TIMER_W'(PROG_CYC);
					end
				end
				S_PP_WAIT: begin
					if (timer_q == '0 && !req_q) begin
						state_q <= S_PP_VERIFY;
						issue(1'b0, fce_pkg::CMD_PROG_VERIFY);
					end
				end
				S_PP_VERIFY: begin
					if (bus_done_q) begin
						state_q <= S_PP_READ;
						timer_q <= fce_pkg::TIMER_W'(RECOV_CYC);
					end
				end
				S_PP_READ: begin
					if (timer_q == '0 && !req_q && !bus_done_q) begin
						issue(1'b1, 8'h00);
					end
					if (bus_done_q) begin
						if (rd_data_q == fce_pkg::PROG_VALUE) begin
							prog_tries_q <= '0;
							if (addr_q == LAST_A) begin
								addr_q   <= '0;
								FL_ADDR  <= '0;
								pulses_q <= '0;
								state_q  <= S_ER_SETUP;
								issue(1'b0, fce_pkg::CMD_ERASE);
							end else begin
								addr_q  <= addr_q + 1'b1;
								FL_ADDR <= addr_q + 1'b1;
								state_q <= S_PP_SETUP;
								issue(1'b0, fce_pkg::CMD_PROG_SETUP);
							end
						end else if (32'(prog_tries_q) >= fce_pkg::MAX_PROG_PULSES - 1) begin
							final_q <= 1'b0;
							state_q <= S_READ_CMD;
							FAIL    <= 1'b1;
							issue(1'b0, fce_pkg::CMD_READ);
						end else begin
							prog_tries_q <= prog_tries_q + 1'b1;
							state_q      <= S_PP_SETUP;
							issue(1'b0, fce_pkg::CMD_PROG_SETUP);
						end
					end
				end
				S_ER_SETUP: begin
					if (bus_done_q) begin
						state_q <= S_ER_EXEC;
						issue(1'b0, fce_pkg::CMD_ERASE);
					end
				end
				S_ER_EXEC: begin
					if (bus_done_q) begin
						pulses_q <= pulses_q + 1'b1;
						state_q  <= S_ER_WAIT;
						timer_q  <= fce_pkg::TIMER_W'(ERASE_CYC);
					end
				end
				S_ER_WAIT: begin
					// No bus cycle may run while the pulse is in progress.
					if (timer_q == '0) begin
						state_q <= S_EV_CMD;
						FL_ADDR <= addr_q;
						issue(1'b0, fce_pkg::CMD_ERASE_VERIFY);
					end
				end
				S_EV_CMD: begin
					if (bus_done_q) begin
						state_q <= S_EV_READ;
						timer_q <= fce_pkg::TIMER_W'(RECOV_CYC);
					end
				end
				S_EV_READ: begin
					if (timer_q == '0 && !req_q && !bus_done_q) begin
						issue(1'b1, 8'h00);
					end
					if (bus_done_q) begin
						if (rd_data_q == fce_pkg::ERASED_VALUE) begin
							if (addr_q == LAST_A) begin
								final_q <= 1'b1;
								state_q <= S_READ_CMD;
								issue(1'b0, fce_pkg::CMD_READ);
							end else begin
								addr_q  <= addr_q + 1'b1;
								FL_ADDR <= addr_q + 1'b1;
								state_q <= S_EV_CMD;
								issue(1'b0, fce_pkg::CMD_ERASE_VERIFY);
							end
						end else if (limit_hit(pulses_q)) begin
							final_q <= 1'b0;
							FAIL    <= 1'b1;
							state_q <= S_READ_CMD;
							issue(1'b0, fce_pkg::CMD_READ);
						end else begin
							// Address is kept so verify resumes here.
							state_q <= S_ER_SETUP;
							issue(1'b0, fce_pkg::CMD_ERASE);
						end
					end
				end
				S_READ_CMD: begin
					if (bus_done_q) begin
						BUSY    <= 1'b0;
						DONE    <= final_q;
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	sequence s_exec_write;
		state_q == S_ER_EXEC && bus_done_q;
	endsequence

	a_erase_wait_idle: assert property (@(posedge CLK) disable iff (!RESET_N)
		state_q == S_ER_WAIT |-> FL_WE_N && FL_CE_N)
		else $error("Bus active during erase pulse.");

	a_two_step_erase: assert property (@(posedge CLK) disable iff (!RESET_N)
		s_exec_write |=> $past(req_data_q, 2) == fce_pkg::CMD_ERASE && state_q == S_ER_WAIT)
		else $error("Erase execute not preceded by erase command.");

	a_pulse_count: assert property (@(posedge CLK) disable iff (!RESET_N)
		s_exec_write |=> pulses_q == $past(pulses_q) + 16'h0001)
		else $error("Pulse counter did not advance.");

	a_write_select: assert property (@(posedge CLK) disable iff (!RESET_N)
		!FL_WE_N |-> !FL_CE_N && FL_OE_N)
		else $error("Write strobe without chip select.");

	a_recovery_read: assert property (@(posedge CLK) disable iff (!RESET_N)
		$fell(FL_OE_N) && state_q == S_EV_READ |-> timer_q == '0)
		else $error("Read before recovery elapsed.");

	a_verify_after_erase: assert property (@(posedge CLK) disable iff (!RESET_N)
		$rose(state_q == S_EV_CMD) |-> $past(state_q) inside {S_ER_WAIT, S_EV_READ})
		else $error("Erase-verify outside erase flow.");

	a_fail_limit: assert property (@(posedge CLK) disable iff (!RESET_N)
		$rose(FAIL) && $past(state_q) == S_EV_READ |-> limit_hit(pulses_q))
		else $error("Failure flagged before pulse limit.");

	a_done_read_mode: assert property (@(posedge CLK) disable iff (!RESET_N)
		$rose(DONE) |-> $past(req_data_q) == fce_pkg::CMD_READ)
		else $error("Done without read command.");
endmodule : fce_seq
`default_nettype wire

// File: hw/fce_pkg.sv
// Constants for the host-side chip-erase sequencer of a byte-wide flash.
// Assumes a 200 MHz system clock and a flash reached over plain parallel pins.
package fce_pkg;
	localparam int          CLK_MHZ          = 200;
	localparam int          ADDR_W           = 15;
	localparam int          DATA_W           = 8;
	localparam logic [7:0]  CMD_ERASE        = 8'h20;
	localparam logic [7:0]  CMD_ERASE_VERIFY = 8'ha0;
	localparam logic [7:0]  CMD_READ         = 8'h00;
	localparam logic [7:0]  PROG_VALUE       = 8'h00;
	localparam logic [7:0]  ERASED_VALUE     = 8'hff;
	localparam logic [7:0]  CMD_PROG_SETUP   = 8'h40;
	localparam logic [7:0]  CMD_PROG_VERIFY  = 8'hc0;
	// Erase pulse time in tenths of a microsecond (9.5 ms), least time, rounds up.
	localparam int          ERASE_PULSE_US10 = 95000;
	localparam int          ERASE_PULSE_CYC  = (ERASE_PULSE_US10 * CLK_MHZ + 9) / 10;
	// Write-to-read recovery in microseconds, least time.
	localparam int          RECOVERY_US      = 6;
	localparam int          RECOVERY_CYC     = RECOVERY_US * CLK_MHZ;
	// Program pulse duration in microseconds, least time.
	localparam int          PROG_PULSE_US    = 10;
	localparam int          PROG_PULSE_CYC   = PROG_PULSE_US * CLK_MHZ;
	// Strobe phase lengths: write pulse 80 ns, read access 150 ns, gaps 30 ns.
	localparam int          STROBE_NS        = 80;
	localparam int          STROBE_CYC       = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int          ACCESS_NS        = 150;
	localparam int          ACCESS_CYC       = (ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int          GAP_NS           = 30;
	localparam int          GAP_CYC          = (GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int          MAX_ERASE_PULSES = 1000;
	localparam int          MAX_PROG_PULSES  = 25;
	localparam int          TIMER_W          = 24;
endpackage : fce_pkg

// File: tb/fce_flash_model.sv
// Behavioural byte-wide flash for the erase sequencer bench: commands, array, verify reads.
// Assumes the host pins come straight from fce_seq; timing limits are given in ns.
`timescale 1ns/100ps
`default_nettype none
module fce_flash_model #(
	parameter int DEPTH    = 4,
	parameter int ERASE_NS = 250,
	parameter int RECOV_NS = 50
) (
	input  wire logic                       ce_n,
	input  wire logic                       oe_n,
	input  wire logic                       we_n,
	input  wire logic [fce_pkg::ADDR_W-1:0] addr,
	input  wire logic [7:0]                 dq_w,
	input  wire logic                       host_oe,
	output var  logic [7:0]                 dq_r
);
	logic [7:0]                 mem [DEPTH];
	int                         need [DEPTH];
	int                         pulses, viol, last_v;
	logic [7:0]                 cmd, last_out, rd_val;
	logic [fce_pkg::ADDR_W-1:0] waddr, paddr;
	realtime                    t_rise, t_erase;
	bit                         erasing, erased;
	wire logic                  strobe_n = ce_n | we_n;

	// Power-up leaves the command register in read mode, whatever the supply order.
	initial begin
		cmd = 8'h00;
		viol = 0;
		last_out = 8'h00;
		t_rise = 0;
		erasing = 0;
	end

	// The byte address is taken as the strobe falls; a cut-short erase pulse is flagged.
	always @(negedge strobe_n) begin
		waddr = addr;
		if (erasing && $realtime - t_erase < ERASE_NS) viol++;
	end

	// Commands act on the rising strobe, so the array changes only on a second step.
	always @(posedge strobe_n) begin
		t_rise = $realtime;
		if (erasing) begin
			erasing = 0;
			pulses++;
			for (int i = 0; i < DEPTH; i++) if (need[i] <= pulses) mem[i] = 8'hff;
		end
		if (cmd == 8'h40) begin
			paddr = waddr;
			mem[waddr] = mem[waddr] & dq_w;
			cmd = 8'h41;
		end else if (cmd == 8'h20 && dq_w == 8'h20) begin
			if (!erased) for (int i = 0; i < DEPTH; i++) if (mem[i] !== 8'h00) viol++;
			erasing = 1;
			erased = 1;
			t_erase = $realtime;
			cmd = 8'h21;
		end else begin
			if (dq_w == 8'ha0 && (!erased || waddr < last_v || waddr > last_v + 1)) viol++;
			if (dq_w == 8'ha0) last_v = waddr;
			cmd = dq_w;
		end
	end

	// Verify modes return the latched byte; plain reads follow the address pins.
	always @* begin
		case (cmd)
			8'ha0: rd_val = mem[last_v];
			8'hc0: rd_val = mem[paddr];
			default: rd_val = mem[addr];
		endcase
	end

	// Outputs drive only while selected and enabled; otherwise they wander, not hold.
	assign dq_r = (!ce_n && !oe_n) ? rd_val : ~last_out;

	// A read must wait out the recovery time and find the host off the bus.
	always @(negedge oe_n) if (!ce_n && ($realtime - t_rise < RECOV_NS || host_oe)) viol++;

	// Remember the last value so the released bus shows something different.
	always @(posedge oe_n) last_out = rd_val;
endmodule : fce_flash_model
`default_nettype wire

// File: tb/fce_seq_test.sv
// Self-checking bench for fce_seq with a behavioural flash on the far side.
// Assumes fce_flash_model and shortened pulse, recovery and array parameters.
`timescale 1ns/100ps
`default_nettype none
module fce_seq_test;
	localparam int LAST = 3;
	localparam int MAXP = 4;
	logic        clk, reset_n, start, busy, done, fail, dq_oe, ce_n, oe_n, we_n;
	logic [15:0] pulse_count;
	logic [14:0] addr;
	logic [7:0]  dq_o, dq_r, dq_bus;
	int          miscompares, n_compared, seed;

	// The shared data wire carries whichever side is driving.
	assign dq_bus = dq_oe ? dq_o : dq_r;

	fce_seq #(.ERASE_CYC(50), .RECOV_CYC(10), .PROG_CYC(10), .LAST_ADDR(LAST),
		.MAX_PULSES(MAXP)) fce_seq_i (
		.CLK(clk), .RESET_N(reset_n), .START(start), .BUSY(busy), .DONE(done), .FAIL(fail),
		.PULSE_COUNT(pulse_count), .FL_ADDR(addr), .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe),
		.FL_DQ_I(dq_bus), .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n));
	fce_flash_model #(.DEPTH(LAST + 1), .ERASE_NS(250), .RECOV_NS(50)) fce_flash_model_i (
		.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_w(dq_bus),
		.host_oe(dq_oe), .dq_r(dq_r));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test

	// One erase run; bytes need random pulse counts, and a run may be cut by reset.
	task automatic run(input int maxneed, input bit kill);
		int worst;
		int k;
		worst = 0;
		for (int i = 0; i <= LAST; i++) begin
			fce_flash_model_i.need[i] = 1 + $unsigned($random(seed)) % maxneed;
			fce_flash_model_i.mem[i] = 8'($random(seed));
			if (fce_flash_model_i.need[i] > worst) worst = fce_flash_model_i.need[i];
		end
		if (maxneed > MAXP) fce_flash_model_i.need[LAST] = maxneed;
		if (maxneed > MAXP) worst = maxneed;
		fce_flash_model_i.pulses = 0;
		fce_flash_model_i.erased = 0;
		fce_flash_model_i.erasing = 0;
		fce_flash_model_i.last_v = 0;
		start = 1'b1;
		k = 0;
		while (busy !== 1'b1 && k < 10) begin
			@(negedge clk);
			k++;
		end
		repeat (3) @(negedge clk);
		check({busy, done, fail}, 3'h4);
		check(pulse_count, 16'h0000);
		repeat (20) @(negedge clk);
		start = 1'b0;
		if (kill) begin
			repeat (100 + $unsigned($random(seed)) % 1500) @(negedge clk);
			reset_n = 1'b0;
			repeat (10) @(negedge clk);
			check({busy, done, fail, dq_oe, ce_n, oe_n, we_n}, 7'h07);
			// A cut sequence leaves the flash mid-command; the restart assumes read mode.
			fce_flash_model_i.cmd = 8'h00;
			reset_n = 1'b1;
			return;
		end
		k = 0;
		while (busy === 1'b1 && k < 30000) begin
			@(negedge clk);
			k++;
		end
		repeat (2) @(negedge clk);
		check({done, fail}, {worst <= MAXP, worst > MAXP});
		check(pulse_count, 16'(worst > MAXP ? MAXP : worst));
		check(fce_flash_model_i.cmd, 8'h00);
		check(16'(fce_flash_model_i.viol), 16'h0000);
		check({ce_n, oe_n, we_n, dq_oe}, 4'he);
		for (int i = 0; i <= LAST; i++) if (worst <= MAXP) check(fce_flash_model_i.mem[i], 8'hff);
	endtask : run

	// Clock at 200 MHz.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// A hang ends the run through the same closing task.
	initial begin
		repeat (90000) @(posedge clk);
		miscompares++;
		finish_test();
	end

	// Reset, then plain, random, failing, interrupted and recovery runs.
	initial begin
		seed = 40019;
		miscompares = 0;
		n_compared = 0;
		reset_n = 1'b0;
		start = 1'b0;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		run(1, 1'b0);
		for (int r = 0; r < 3; r++) run(MAXP, 1'b0);
		run(MAXP + 1, 1'b0);
		run(MAXP, 1'b1);
		run(MAXP, 1'b0);
		finish_test();
	end
endmodule : fce_seq_test
`default_nettype wire
